// File: dv/ssc_ctrl_model.sv
// Camera controller model: writes configuration words over the three-wire link.
// Assumes the core clock is supplied only to pace the link edges.
`timescale 1ns/1ps
module ssc_ctrl_model
  import ssc_pkg::*;
(
  input  wire logic clk,
  input  wire logic frame_valid,
  output logic      spi_clk,
  output logic      spi_data,
  output logic      spi_enable
);
  // Seven core cycles a half period keeps the link under 20 MHz
  localparam int HALF = 7;

  initial
  begin
    spi_clk    = 1'b0;
    spi_data   = 1'b0;
    spi_enable = 1'b0;
  end

  task automatic write_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [WORD_W-1:0] word;
    int                n;
    word = {a, d};
    n = 0;
    // Writes wait for the frame overhead, for at most 20000 core cycles
    while (frame_valid !== 1'b0 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      spi_data = word[i];
      repeat (HALF) @(negedge clk);
      spi_clk = 1'b1;
      repeat (HALF) @(negedge clk);
      spi_clk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    spi_enable = 1'b1;
    repeat (HALF + 1) @(negedge clk);
    spi_enable = 1'b0;
    // Released data line must not keep the last bit
    spi_data = ~word[0];
    repeat (HALF + 1) @(negedge clk);
  endtask
endmodule

// File: dv/tb_ssc_config_regs.sv
// Testbench of the sequencer configuration bank: serial writes, field outputs, frame timing.
// Assumes the controller model paces the link; the bench drives reset and integration pins.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_ssc_config_regs;
  import ssc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        reset_n  = 1'b0;
  logic [3:1]  int_t    = 3'h0;
  logic        spi_clk, spi_data, spi_en;
  logic        seq_tick, fv, lv, pix, ds, ts, cal, ft;
  logic [8:0]  row;
  logic [10:0] col;
  logic [1:0]  gran;
  logic        aout, amp_unity, pre_unity, ain, fcal;
  logic [7:0]  vcal, vblk, voff;
  logic [3:0]  tsel, psel, byp, gain, adcen;
  logic [32:0] cword;
  logic [80:0] snap;
  logic [8:0]  first_row, second_row;
  logic [10:0] first_col;
  int          errors = 0;
  int          checked = 0;
  int          n_lines, width, pix_lines, calib_n, ds_len, ts_len, ticks, ft_n, ft_at;

  always #2 core_clk = ~core_clk;

  ssc_ctrl_model i_ctrl (.clk(core_clk), .frame_valid(fv), .spi_clk(spi_clk), .spi_data(spi_data),
    .spi_enable(spi_en));

  ssc_config_regs i_dut (.CORE_CLK(core_clk), .RST(rst), .SPI_CLK(spi_clk), .SPI_DATA(spi_data),
    .SPI_ENABLE(spi_en), .RESET_N(reset_n), .INT_TIME_1(int_t[1]), .INT_TIME_2(int_t[2]),
    .INT_TIME_3(int_t[3]), .SEQ_TICK(seq_tick), .FRAME_VALID(fv), .LINE_VALID(lv), .ROW_ADDR(row),
    .COL_PIXEL(col), .PIX_RESET(pix), .DS_RESET(ds), .TS_RESET(ts), .FRAME_TRANSFER(ft),
    .CALIB_PULSE(cal), .GRANULARITY(gran), .ANALOG_OUT_EN(aout), .DAC_VCAL(vcal),
    .DAC_VBLACK(vblk), .DAC_VOFFSET(voff), .TEST_PATH_SEL(tsel), .PATH_SEL(psel),
    .MUX_BYPASS(byp), .AMP_GAIN(gain), .AMP_UNITY(amp_unity), .PREAMP_UNITY(pre_unity),
    .ANALOG_IN_EN(ain), .ADC_ENABLE(adcen), .ADC_FAST_CAL(fcal), .CALIB_WORD(cword));

  // Register contents as seen on the field outputs, converter input and amplifier in register order
  assign snap = {vcal, vblk, voff, byp, psel, tsel, fcal, adcen, ain, pre_unity, amp_unity, gain, cword};

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Releases the sequencer for one frame and measures it, then halts it again
  task automatic run_frame();
    int  cyc;
    bit  prev_lv;
    n_lines = 0; width = 0; pix_lines = 0; calib_n = 0; ds_len = 0; ts_len = 0; ticks = 0;
    prev_lv = 1'b0;
    ft_n = 0;
    ft_at = 0;
    cyc = 0;
    reset_n = 1'b1;
    while (fv !== 1'b1 && cyc < 2000)
    begin
      @(negedge core_clk);
      cyc++;
    end
    cyc = 0;
    while (fv === 1'b1 && cyc < 20000)
    begin
      if (cyc < 40 && seq_tick === 1'b1) ticks++;
      if (cal === 1'b1) calib_n++;
      if (ds === 1'b1) ds_len++;
      if (ts === 1'b1) ts_len++;
      // Lines already read when the transfer pulse appears
      if (ft === 1'b1)
      begin
        ft_n++;
        ft_at = n_lines;
      end
      if (lv === 1'b1)
      begin
        if (!prev_lv)
        begin
          if (n_lines == 0) first_row = row;
          if (n_lines == 0) first_col = col;
          if (n_lines == 1) second_row = row;
          if (pix === 1'b1) pix_lines++;
          n_lines++;
        end
        if (n_lines == 1) width++;
      end
      prev_lv = (lv === 1'b1);
      @(negedge core_clk);
      cyc++;
    end
    reset_n = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  initial
  begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK(snap, {8'h4a, 8'h6b, 8'h55, 12'h0f0, 12'hfb0, 9'h0db, 12'h6db, 12'hadf})
    `CHK(gran, 2'b10)
    `CHK(aout, 1'b0)
    // Upper bits beyond each register width must be dropped
    i_ctrl.write_reg(A_VCAL, 12'hfa5);
    i_ctrl.write_reg(A_VBLK, 12'h13c);
    i_ctrl.write_reg(A_VOFF, 12'hfff);
    i_ctrl.write_reg(A_ADCIN, 12'h5a3);
    i_ctrl.write_reg(A_AMP, 12'h7e2);
    i_ctrl.write_reg(A_TRIM_LO, 12'h123);
    i_ctrl.write_reg(A_TRIM_MID, 12'h456);
    i_ctrl.write_reg(A_TRIM_HI, 12'hfff);
    `CHK(snap, {8'ha5, 8'h3c, 8'hff, 12'h5a3, 12'h7e2, 9'h1ff, 12'h456, 12'h123})
    `CHK(pre_unity, 1'b1)
    i_ctrl.write_reg(A_AMP, 12'h7c2);
    `CHK(pre_unity, 1'b0)
    // Granularity follows each timing write, here made with the sequencer held in reset
    for (int g = 0; g < 4; g++)
    begin
      i_ctrl.write_reg(A_TIMING, {8'h03, g[1:0], 2'b01});
      `CHK(gran, g[1:0])
      `CHK(aout, 1'b1)
    end
    i_ctrl.write_reg(A_COL, 12'h017);
    i_ctrl.write_reg(A_ROW, 12'h1d6);
    i_ctrl.write_reg(A_KERN, 12'h003);
    i_ctrl.write_reg(A_RSTLEN, 12'h003);
    i_ctrl.write_reg(A_DS, 12'h002);
    i_ctrl.write_reg(A_TS, 12'h004);
    i_ctrl.write_reg(A_FT, 12'h005);
    // Master, line calibration, both extra slopes, granularity 0
    i_ctrl.write_reg(A_TIMING, 12'h0e1);
    run_frame();
    `CHK(ticks, 10)
    `CHK(n_lines, 10)
    `CHK(first_row, 9'd470)
    `CHK(first_col, 11'd184)
    `CHK(width, 12)
    `CHK(pix_lines, 2)
    `CHK(calib_n, 10)
    `CHK(ds_len, 52)
    `CHK(ts_len, 52)
    `CHK(ft_n, 1)
    `CHK(ft_at, 4)
    // Row skip, granularity 1, frame calibration, dual only, both reversed, keep-charge
    i_ctrl.write_reg(A_TIMING, 12'h747);
    run_frame();
    `CHK(n_lines, 5)
    `CHK(first_row, 9'd9)
    `CHK(second_row, 9'd7)
    `CHK(first_col, 11'd455)
    `CHK(calib_n, 1)
    `CHK(ds_len, 100)
    `CHK(ts_len, 0)
    `CHK(pix_lines, 0)
    `CHK(ft_n, 1)
    // Slave mode: integration follows the three pins
    i_ctrl.write_reg(A_TIMING, 12'h028);
    reset_n = 1'b1;
    int_t = 3'b011;
    repeat (8) @(negedge core_clk);
    `CHK({ts, ds, pix}, 3'b010)
    int_t = 3'b100;
    repeat (8) @(negedge core_clk);
    `CHK({ts, ds, pix}, 3'b101)
    reset_n = 1'b0;
    complete_run();
  end

  // Cuts a hang short
  initial
  begin
    #240000;
    errors++;
    complete_run();
  end
endmodule

// File: pkg/ssc_pkg.sv
// Constants, register map and types of the sensor sequencer configuration bank.
// Assumes one core clock; the sequencer ticks once every CLK_DIV core cycles.
package ssc_pkg;
  localparam int AW     = 4;
  localparam int DW     = 12;
  localparam int NREG   = 16;
  localparam int WORD_W = 16;
  localparam int WORD_ADDR_LO = 12;

  localparam logic [AW-1:0] A_TIMING = 4'h0, A_COL = 4'h1, A_ROW = 4'h2, A_KERN = 4'h3;
  localparam logic [AW-1:0] A_RSTLEN = 4'h4, A_DS = 4'h5, A_TS = 4'h6, A_FT = 4'h7;
  localparam logic [AW-1:0] A_VCAL = 4'h8, A_VBLK = 4'h9, A_VOFF = 4'ha, A_ADCIN = 4'hb;
  localparam logic [AW-1:0] A_AMP = 4'hc, A_TRIM_LO = 4'hd, A_TRIM_MID = 4'he, A_TRIM_HI = 4'hf;

  // Index 15 first
  localparam logic [NREG-1:0][DW-1:0] REG_RESET = {
    12'h0db, 12'h6db, 12'hadf, 12'hfb0, 12'h0f0, 12'h055, 12'h06b, 12'h04a,
    12'h1e1, 12'h000, 12'h000, 12'h002, 12'h0a0, 12'h000, 12'h000, 12'h029};
  localparam logic [NREG-1:0][DW-1:0] REG_MASK = {
    12'h1ff, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h0ff, 12'h0ff, 12'h0ff,
    12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h0ff, 12'h1ff, 12'h0ff, 12'h7ff};

  // Timing control fields
  localparam int B_MASTER = 0, B_SS = 1, B_GRAN = 2, B_AOUT = 4, B_CALLINE = 5;
  localparam int B_DSEN = 6, B_TSEN = 7, B_REVX = 8, B_REVY = 9, B_NDR = 10;
  // Amplifier fields
  localparam int B_GAIN = 0, B_UNITY = 4, B_SELUNI = 5, B_AIN = 6, B_ADCEN = 7, B_FASTCAL = 11;
  // Converter input fields
  localparam int B_TEST = 0, B_PATH = 4, B_BYP = 8;
  localparam int TRIM_LO_W = 12, TRIM_HI_W = 9;

  localparam logic [1:0]  DIV_LAST    = 2'h3;
  localparam int          CLK_DIV     = 4;
  localparam int          SLOPE_LINES = 12;
  localparam logic [7:0]  FOT_LAST    = 8'h1f;
  localparam logic [7:0]  ROT_LAST    = 8'h07;
  localparam logic [9:0]  LAST_ROW    = 10'h1df;
  localparam logic [10:0] LAST_PIX    = 11'h27f;
  localparam logic [10:0] GROUP_PIX   = 11'h008;
  localparam logic [10:0] KERN_PIX    = 11'h004;
  localparam logic [9:0]  SS_STEP     = 10'h002;
  localparam logic [9:0]  ROW_STEP    = 10'h001;

  // Synchronised pin levels
  localparam int L_RUN = 0, L_INT1 = 1, L_INT2 = 2, L_INT3 = 3, NPIN = 4;
  localparam int RX_SCK = 0, RX_SDI = 1, RX_SEN = 2;

  typedef enum logic [3:0] {
    SQ_HALT = 4'b0001,
    SQ_FOT  = 4'b0010,
    SQ_ROT  = 4'b0100,
    SQ_READ = 4'b1000
  } ssc_seq_t;
endpackage

// File: pkg/ssc_wr_if.sv
// Register write strobe from the serial receiver to the register bank.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface ssc_wr_if;
  import ssc_pkg::*;
  logic          valid;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;
  modport src (output valid, output addr, output data);
  modport dst (input valid, input addr, input data);
endinterface

// File: src/ssc_config_regs.sv
// Sensor sequencer: configuration registers written over the serial link,
// frame/line sequencer and integration pulses. Assumes the serial link and
// the sequencer reset and integration pins are asynchronous to CORE_CLK.
// Operation
// - Sequencer ticks at core clock divided by four
// - Master generates integration; slave follows three pins
// - Row skip reads every other line; reset clear
// - Two-bit granularity selects system clock range
// - Analog output amplifier enable, off at reset
// - Calibrate every line, or once per frame
// - Dual-slope reset at its position when enabled
// - Triple-slope reset at its position when enabled
// - Horizontal reverse reads columns right to left
// - Vertical reverse reads lines bottom to top
// - Keep-charge readout suppresses pixel array reset
// - Column start selects group of eight pixels
// - Row start may be any line 0-479
// - Line width is kernel count times four
// - Pixel reset high for length minus one lines
// - Preamp select: zero attenuates half, one unity
// - Amplifier fields: gain, unity, input, converter enables
// - Converter input: test path, path, mux bypass
// - Calibration word built from three trim registers
// - Serial word: address 15:12, data 11:0
// - Slope pulses last 4*(12*(gran+1)+1) cycles
`timescale 1ns/1ps
module ssc_config_regs (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SPI_CLK,
  input  wire logic        SPI_DATA,
  input  wire logic        SPI_ENABLE,
  input  wire logic        RESET_N,
  input  wire logic        INT_TIME_1,
  input  wire logic        INT_TIME_2,
  input  wire logic        INT_TIME_3,
  output logic             SEQ_TICK,
  output logic             FRAME_VALID,
  output logic             LINE_VALID,
  output logic [8:0]       ROW_ADDR,
  output logic [10:0]      COL_PIXEL,
  output logic             PIX_RESET,
  output logic             DS_RESET,
  output logic             TS_RESET,
  output logic             FRAME_TRANSFER,
  output logic             CALIB_PULSE,
  output logic [1:0]       GRANULARITY,
  output logic             ANALOG_OUT_EN,
  output logic [7:0]       DAC_VCAL,
  output logic [7:0]       DAC_VBLACK,
  output logic [7:0]       DAC_VOFFSET,
  output logic [3:0]       TEST_PATH_SEL,
  output logic [3:0]       PATH_SEL,
  output logic [3:0]       MUX_BYPASS,
  output logic [3:0]       AMP_GAIN,
  output logic             AMP_UNITY,
  output logic             PREAMP_UNITY,
  output logic             ANALOG_IN_EN,
  output logic [3:0]       ADC_ENABLE,
  output logic             ADC_FAST_CAL,
  output logic [32:0]      CALIB_WORD
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][DW-1:0] regs;
    logic [NPIN-1:0][2:0]    sy;
    logic [NPIN-1:0]         lvl;
    logic [1:0]              div;
    logic                    tick;
    ssc_seq_t                seq;
    logic [7:0]              cnt;
    logic [11:0]             line;
    logic [9:0]              row_off;
    logic [7:0]              kern;
    logic [7:0]              ds_cnt;
    logic [7:0]              ts_cnt;
    logic [7:0]              ds_run;
    logic                    fv;
    logic                    lv;
    logic                    pixrst;
    logic                    ds;
    logic                    ts;
    logic                    ft;
    logic                    cal;
    logic [8:0]              row_addr;
    logic [10:0]             col_pix;
  } ssc_st_t;

  localparam ssc_st_t ST_RESET = '{regs: REG_RESET, seq: SQ_HALT, default: '0};

  function automatic logic [7:0] slope_len(input logic [1:0] g);
    slope_len = 8'(CLK_DIV * (SLOPE_LINES * (int'(g) + 1) + 1));
  endfunction

  function automatic logic [8:0] row_map(input logic [9:0] off, input logic [8:0] start, input logic rev);
    logic [9:0] r;
    r = 10'(start) + off;
    row_map = rev ? 9'(LAST_ROW - r) : 9'(r);
  endfunction

  function automatic logic [10:0] col_map(input logic [7:0] k, input logic [7:0] start, input logic rev);
    logic [10:0] p;
    p = 11'(11'(start) * GROUP_PIX + 11'(k) * KERN_PIX);
    col_map = rev ? 11'(LAST_PIX - p) : p;
  endfunction

  ssc_st_t q;
  ssc_st_t d;
  ssc_wr_if wr ();

  logic [DW-1:0]   tc;
  logic            master;
  logic            ss;
  logic [1:0]      gran;
  logic            ds_en;
  logic            ts_en;
  logic            ndr;
  logic            calline;
  logic [NPIN-1:0] pins;

  ssc_serial_rx u_rx (
    .clk     (CORE_CLK),
    .rst     (RST),
    .sclk    (SPI_CLK),
    .sdata   (SPI_DATA),
    .senable (SPI_ENABLE),
    .wr      (wr)
  );

  assign pins    = {INT_TIME_3, INT_TIME_2, INT_TIME_1, RESET_N};
  assign tc      = q.regs[A_TIMING];
  assign master  = tc[B_MASTER];
  assign ss      = tc[B_SS];
  assign gran    = tc[B_GRAN +: 2];
  assign ds_en   = tc[B_DSEN];
  assign ts_en   = tc[B_TSEN];
  assign ndr     = tc[B_NDR];
  assign calline = tc[B_CALLINE];

  always_comb
  begin
    logic       line_go;
    logic [9:0] nxt;
    logic [7:0] kern_last;
    line_go   = 1'b0;
    nxt       = q.row_off + (ss ? SS_STEP : ROW_STEP);
    kern_last = q.regs[A_KERN][7:0] - 8'h01;
    d = q;
    d.ft  = 1'b0;
    d.cal = 1'b0;
    for (int i = 0; i < NPIN; i++)
    begin
      d.sy[i] = {q.sy[i][1:0], pins[i]};
      if (q.sy[i][1] == q.sy[i][2])
        d.lvl[i] = q.sy[i][2];
    end
    d.div  = q.div + 2'h1;
    d.tick = (q.div == DIV_LAST);
    if (wr.valid)
      d.regs[wr.addr] = wr.data & REG_MASK[wr.addr];
    if (!q.lvl[L_RUN])
    begin
      d.seq  = SQ_HALT;
      d.fv   = 1'b0;
      d.lv   = 1'b0;
      d.line = '0;
    end
    else if (q.tick)
    begin
      case (q.seq)
        SQ_HALT:
        begin
          d.seq     = SQ_FOT;
          d.cnt     = '0;
          d.line    = '0;
          d.row_off = '0;
        end
        SQ_FOT:
        begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == FOT_LAST)
          begin
            d.seq   = SQ_ROT;
            d.cnt   = '0;
            d.fv    = 1'b1;
            line_go = 1'b1;
          end
        end
        SQ_ROT:
        begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == ROT_LAST)
          begin
            d.seq  = SQ_READ;
            d.kern = '0;
            d.lv   = 1'b1;
          end
        end
        SQ_READ:
        begin
          d.kern = q.kern + 8'h01;
          // One kernel of four pixels per tick
          if (q.kern >= kern_last)
          begin
            d.lv  = 1'b0;
            d.cnt = '0;
            if (10'(q.regs[A_ROW][8:0]) + nxt > LAST_ROW)
            begin
              d.seq     = SQ_FOT;
              d.fv      = 1'b0;
              d.line    = '0;
              d.row_off = '0;
            end
            else
            begin
              d.seq     = SQ_ROT;
              d.row_off = nxt;
              line_go   = 1'b1;
            end
          end
        end
        default: d.seq = SQ_HALT;
      endcase
    end
    if (line_go)
    begin
      d.line = q.line + 12'h001;
      d.ft   = (q.line == q.regs[A_FT] - 12'h001);
      d.cal  = calline || (q.line == '0);
    end
    d.row_addr = row_map(d.row_off, q.regs[A_ROW][8:0], tc[B_REVY]);
    d.col_pix  = col_map(d.kern, q.regs[A_COL][7:0], tc[B_REVX]);
    if (master)
    begin
      // Reset drops once length minus one lines are read out
      d.pixrst = !ndr && (q.line < q.regs[A_RSTLEN]);
      if (line_go && ds_en && q.line == q.regs[A_DS] - 12'h001)
        d.ds_cnt = slope_len(gran);
      else if (q.ds_cnt != '0)
        d.ds_cnt = q.ds_cnt - 8'h01;
      if (line_go && ts_en && q.line == q.regs[A_TS] - 12'h001)
        d.ts_cnt = slope_len(gran);
      else if (q.ts_cnt != '0)
        d.ts_cnt = q.ts_cnt - 8'h01;
      d.ds = (d.ds_cnt != '0);
      d.ts = (d.ts_cnt != '0);
    end
    else
    begin
      // Integration pins drive the pulses directly
      d.ds_cnt = '0;
      d.ts_cnt = '0;
      d.pixrst = !q.lvl[L_INT1];
      d.ds     = q.lvl[L_INT2];
      d.ts     = q.lvl[L_INT3];
    end
    d.ds_run = d.ds ? q.ds_run + 8'h01 : '0;
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      q <= ST_RESET;
    else
      q <= d;
  end

  assign SEQ_TICK       = q.tick;
  assign FRAME_VALID    = q.fv;
  assign LINE_VALID     = q.lv;
  assign ROW_ADDR       = q.row_addr;
  assign COL_PIXEL      = q.col_pix;
  assign PIX_RESET      = q.pixrst;
  assign DS_RESET       = q.ds;
  assign TS_RESET       = q.ts;
  assign FRAME_TRANSFER = q.ft;
  assign CALIB_PULSE    = q.cal;
  assign GRANULARITY    = q.regs[A_TIMING][B_GRAN +: 2];
  assign ANALOG_OUT_EN  = q.regs[A_TIMING][B_AOUT];
  assign DAC_VCAL       = q.regs[A_VCAL][7:0];
  assign DAC_VBLACK     = q.regs[A_VBLK][7:0];
  assign DAC_VOFFSET    = q.regs[A_VOFF][7:0];
  assign TEST_PATH_SEL  = q.regs[A_ADCIN][B_TEST +: 4];
  assign PATH_SEL       = q.regs[A_ADCIN][B_PATH +: 4];
  assign MUX_BYPASS     = q.regs[A_ADCIN][B_BYP +: 4];
  assign AMP_GAIN       = q.regs[A_AMP][B_GAIN +: 4];
  assign AMP_UNITY      = q.regs[A_AMP][B_UNITY];
  assign PREAMP_UNITY   = q.regs[A_AMP][B_SELUNI];
  assign ANALOG_IN_EN   = q.regs[A_AMP][B_AIN];
  assign ADC_ENABLE     = q.regs[A_AMP][B_ADCEN +: 4];
  assign ADC_FAST_CAL   = q.regs[A_AMP][B_FASTCAL];
  assign CALIB_WORD     = {q.regs[A_TRIM_HI][TRIM_HI_W-1:0], q.regs[A_TRIM_MID],
                           q.regs[A_TRIM_LO][TRIM_LO_W-1:0]};

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence s_tick_gap;
    !q.tick [*3];
  endsequence
  sequence s_line_end_ss;
    q.tick && q.seq == SQ_READ && d.seq == SQ_ROT && ss;
  endsequence

  property p_div;
    q.tick |=> s_tick_gap ##1 q.tick;
  endproperty
  a_div: assert property (p_div) else $error("sequencer tick not one in four");

  property p_wr_load;
    wr.valid && wr.addr == A_TIMING |=> q.regs[A_TIMING] == ($past(wr.data) & REG_MASK[A_TIMING]);
  endproperty
  a_wr_load: assert property (p_wr_load) else $error("timing register not loaded");

  property p_wr_mask;
    wr.valid && wr.addr == A_TRIM_HI |=> (q.regs[A_TRIM_HI] & ~REG_MASK[A_TRIM_HI]) == '0;
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("unused bits stored");

  property p_row_skip;
    s_line_end_ss |=> q.row_off == $past(q.row_off) + SS_STEP;
  endproperty
  a_row_skip: assert property (p_row_skip) else $error("row skip step wrong");

  property p_ds_len;
    $fell(q.ds) && master && $past(master) |-> $past(q.ds_run) == slope_len(gran);
  endproperty
  a_ds_len: assert property (p_ds_len) else $error("dual-slope pulse length wrong");

  property p_ds_gate;
    $rose(q.ds) && master |-> $past(ds_en);
  endproperty
  a_ds_gate: assert property (p_ds_gate) else $error("dual-slope pulse while disabled");

  property p_ts_gate;
    $rose(q.ts) && master |-> $past(ts_en);
  endproperty
  a_ts_gate: assert property (p_ts_gate) else $error("triple-slope pulse while disabled");

  property p_slave;
    !master && !$past(master) |-> q.pixrst == !$past(q.lvl[L_INT1]);
  endproperty
  a_slave: assert property (p_slave) else $error("slave reset not following pin");

  property p_ndr;
    master && ndr |=> !q.pixrst;
  endproperty
  a_ndr: assert property (p_ndr) else $error("pixel reset during keep-charge");

  property p_col_start;
    $rose(q.lv) && !tc[B_REVX] |-> q.col_pix == 11'(11'(q.regs[A_COL][7:0]) * GROUP_PIX);
  endproperty
  a_col_start: assert property (p_col_start) else $error("line start column wrong");

  property p_cal_frame;
    q.cal && !$past(calline) |-> q.line == 12'h001;
  endproperty
  a_cal_frame: assert property (p_cal_frame) else $error("calibration on later line");
endmodule

// File: src/ssc_serial_rx.sv
// Three-wire serial write receiver: 16-bit word, address on top, data below.
// Assumes the serial pins are asynchronous to the core clock and much slower.
`timescale 1ns/1ps
module ssc_serial_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic senable,
  ssc_wr_if.src    wr
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [2:0][2:0]    sy;
    logic [2:0]         lvl;
    logic [WORD_W-1:0]  shift;
    logic               valid;
    logic [AW-1:0]      addr;
    logic [DW-1:0]      data;
  } ssc_rx_st_t;

  localparam ssc_rx_st_t RX_RESET = '0;

  ssc_rx_st_t q;
  ssc_rx_st_t d;
  logic [2:0] pins;

  assign pins = {senable, sdata, sclk};

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      d.sy[i] = {q.sy[i][1:0], pins[i]};
      // Only a level seen by both later stages counts
      if (q.sy[i][1] == q.sy[i][2])
        d.lvl[i] = q.sy[i][2];
    end
    if (d.lvl[RX_SCK] && !q.lvl[RX_SCK])
      d.shift = {q.shift[WORD_W-2:0], q.lvl[RX_SDI]};
    if (d.lvl[RX_SEN] && !q.lvl[RX_SEN])
    begin
      d.valid = 1'b1;
      d.addr  = q.shift[WORD_W-1:WORD_ADDR_LO];
      d.data  = q.shift[DW-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= RX_RESET;
    else
      q <= d;
  end

  assign wr.valid = q.valid;
  assign wr.addr  = q.addr;
  assign wr.data  = q.data;
endmodule
